// >>> rtl/ccsr_top.v
// charger control/status registers behind a serial two-wire slave port
// assumes scl/sda, undervoltage and source-select pins are asynchronous;
// phase, fault and watchdog expiry come from logic on mclk_i
// Summary of operation
// - writing one to watchdog kick restarts watchdog; bit reads zero
// - boost select: zero charger, one boost; resets to zero
// - boost select one enters boost and regulates input node to 5V
// - fault code bits report eight documented fault codes
// - ship latch turns off device, switch, gate until undervoltage falls
// - host may clear ship latch bit by register write
// - soft reset writes one restore defaults; zero leaves default mode; reads one
// - soft reset enters default mode and stops the watchdog
// - soft reset clears itself once default mode is entered
// - input current limit code selects eight limits; reset 000
// - in default mode limit comes from source select pin
// - status pin enable: zero faults only, one full status; reset one
// - end-current cutoff: zero disables termination, one enables; reset one
// - charge disable: zero allows charging, one stops it
// - charge disabled: fixed system regulation, battery off, supplement allowed
// - high-impedance select one gives low quiescent state; reset zero
// - high impedance: converter off, battery switch on, gate low
// - watchdog expiry in boost clears boost and sends fault pulse
// - in boost status/interrupt float; each fault gives 128us pulse
`timescale 1ns/10ps
`include "ccsr_consts.vh"
module ccsr_top #(
  parameter DEV_ADDR = `CCSR_DEV_ADDR
) (
  // clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // serial port pins, open drain
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // device state
  input wire [1:0] charge_phase_i,
  input wire [2:0] fault_code_i,
  input wire watchdog_expired_i,
  input wire undervoltage_lockout_i,
  input wire source_select_i,
  // watchdog control
  output reg watchdog_kick_o,
  output reg watchdog_run_o,
  // operating mode
  output reg boost_mode_o,
  output reg default_mode_o,
  output reg device_off_o,
  output reg battery_switch_on_o,
  output reg external_battery_gate_o,
  output reg converter_on_o,
  output reg sys_fixed_reg_o,
  output reg supplement_en_o,
  output reg charge_en_o,
  output reg end_current_cutoff_on_o,
  output reg [2:0] input_limit_code_o,
  output reg [11:0] input_limit_ma_o,
  // status and interrupt pins, open drain
  output reg stat_o,
  output reg stat_oe_o,
  output reg int_o,
  output reg int_oe_o
);

  localparam PULSE_CYC = (`CCSR_PULSE_NS * `CCSR_CLK_MHZ) / 1000;
  localparam [7:0] CTRL_RST = `CCSR_CTRL_RESET;

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACKA = 3'd2;
  localparam ST_PTR = 3'd3;
  localparam ST_WDAT = 3'd4;
  localparam ST_ACKW = 3'd5;
  localparam ST_RDAT = 3'd6;
  localparam ST_RACK = 3'd7;

  function [11:0] lim_ma;
    input [2:0] code;
    begin
      case (code)
        3'h0: lim_ma = `CCSR_MA_0;
        3'h1: lim_ma = `CCSR_MA_1;
        3'h2: lim_ma = `CCSR_MA_2;
        3'h3: lim_ma = `CCSR_MA_3;
        3'h4: lim_ma = `CCSR_MA_4;
        3'h5: lim_ma = `CCSR_MA_5;
        3'h6: lim_ma = `CCSR_MA_6;
        default: lim_ma = `CCSR_MA_7;
      endcase
    end
  endfunction

  wire [3:0] pins_s;
  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];
  wire undervoltage_lockout_s = pins_s[2];
  wire psel_s = pins_s[3];

  ccsr_sync #(.W(4)) u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({source_select_i, undervoltage_lockout_i, sda_i, scl_i}),
    .sync_o(pins_s)
  );

  reg scl_d;
  reg sda_d;
  reg undervoltage_lockout_d;
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] txreg;
  reg [7:0] ptr;
  reg is_read;
  reg wr_stb;
  reg [7:0] wr_data;
  reg [7:0] wr_addr;

  // register contents
  reg boost;
  reg ship;
  reg [2:0] in_limit;
  reg stat_en;
  reg term_en;
  reg chg_dis;
  reg hiz;
  reg soft_rst_pend;
  reg [2:0] fault_d;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  wire wdog_boost = watchdog_expired_i & boost;
  wire fault_new = (fault_code_i != fault_d) && (fault_code_i != `CCSR_FAULT_NONE);
  wire pulse;

  ccsr_pulse #(.CYCLES(PULSE_CYC), .W(12)) u_pulse (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .trig_i(boost & (fault_new | watchdog_expired_i)),
    .pulse_o(pulse)
  );

  wire [7:0] status_rd = {1'b0, boost, charge_phase_i, ship, fault_code_i};
  wire [7:0] control_rd = {1'b1, in_limit, stat_en, term_en, chg_dis, hiz};
  reg [7:0] rd_data;

  always @* begin
    case (ptr)
      `CCSR_REG_STATUS: rd_data = status_rd;
      `CCSR_REG_CONTROL: rd_data = control_rd;
      default: rd_data = `CCSR_UNMAPPED_DATA;
    endcase
  end

  // serial slave engine
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 8'h00;
      is_read <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      wr_addr <= 8'h00;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      wr_stb <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDAT: begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          ST_RDAT: begin
            bitcnt <= bitcnt + 4'h1;
          end
          ST_RACK: begin
            if (sda_s) begin
              state <= ST_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (shreg[7:1] == DEV_ADDR) begin
                is_read <= shreg[0];
                sda_oe_o <= 1'b1;
                state <= ST_ACKA;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACKA: begin
            if (is_read) begin
              txreg <= {rd_data[6:0], 1'b0};
              sda_oe_o <= ~rd_data[7];
              state <= ST_RDAT;
            end else begin
              sda_oe_o <= 1'b0;
              state <= ST_PTR;
            end
          end
          ST_PTR, ST_WDAT: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              sda_oe_o <= 1'b1;
              if (state == ST_PTR) begin
                ptr <= shreg;
              end else begin
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr <= ptr + 8'h01;
              end
              state <= ST_ACKW;
            end
          end
          ST_ACKW: begin
            sda_oe_o <= 1'b0;
            state <= ST_WDAT;
          end
          ST_RDAT: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              sda_oe_o <= 1'b0;
              ptr <= ptr + 8'h01;
              state <= ST_RACK;
            end else begin
              sda_oe_o <= ~txreg[7];
              txreg <= {txreg[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            txreg <= {rd_data[6:0], 1'b0};
            sda_oe_o <= ~rd_data[7];
            state <= ST_RDAT;
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  wire wr_status = wr_stb && (wr_addr == `CCSR_REG_STATUS);
  wire wr_control = wr_stb && (wr_addr == `CCSR_REG_CONTROL);

  // register bank and mode control
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      boost <= 1'b0;
      ship <= 1'b0;
      in_limit <= `CCSR_LIM_100;
      stat_en <= CTRL_RST[`CCSR_BIT_STATEN];
      term_en <= CTRL_RST[`CCSR_BIT_TERM];
      chg_dis <= 1'b0;
      hiz <= 1'b0;
      soft_rst_pend <= 1'b0;
      default_mode_o <= 1'b1;
      watchdog_kick_o <= 1'b0;
      watchdog_run_o <= 1'b0;
      undervoltage_lockout_d <= 1'b1;
      fault_d <= `CCSR_FAULT_NONE;
    end else begin
      undervoltage_lockout_d <= undervoltage_lockout_s;
      fault_d <= fault_code_i;
      watchdog_kick_o <= 1'b0;
      if (soft_rst_pend) begin
        boost <= 1'b0;
        ship <= 1'b0;
        in_limit <= `CCSR_LIM_100;
        stat_en <= CTRL_RST[`CCSR_BIT_STATEN];
        term_en <= CTRL_RST[`CCSR_BIT_TERM];
        chg_dis <= 1'b0;
        hiz <= 1'b0;
        default_mode_o <= 1'b1;
        watchdog_run_o <= 1'b0;
        soft_rst_pend <= 1'b0;
      end else begin
        if (wr_status) begin
          // kick is a pulse, never stored
          if (wr_data[`CCSR_BIT_KICK]) begin
            watchdog_kick_o <= 1'b1;
            watchdog_run_o <= 1'b1;
          end
          boost <= wr_data[`CCSR_BIT_BOOST];
          // host sets or clears ship latch
          ship <= wr_data[`CCSR_BIT_SHIP];
          default_mode_o <= 1'b0;
        end else if (undervoltage_lockout_d & ~undervoltage_lockout_s) begin
          ship <= 1'b0;
        end
        if (wr_control) begin
          // only a one starts soft reset
          soft_rst_pend <= wr_data[`CCSR_BIT_SOFTRST];
          in_limit <= wr_data[`CCSR_LIM_HI:`CCSR_LIM_LO];
          stat_en <= wr_data[`CCSR_BIT_STATEN];
          term_en <= wr_data[`CCSR_BIT_TERM];
          chg_dis <= wr_data[`CCSR_BIT_CHGDIS];
          hiz <= wr_data[`CCSR_BIT_HIZ];
          default_mode_o <= wr_data[`CCSR_BIT_SOFTRST];
        end
        if (wdog_boost) begin
          boost <= 1'b0;
        end
      end
    end
  end

  // registered mode and pin outputs
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      boost_mode_o <= 1'b0;
      device_off_o <= 1'b0;
      battery_switch_on_o <= 1'b1;
      external_battery_gate_o <= 1'b0;
      converter_on_o <= 1'b1;
      sys_fixed_reg_o <= 1'b0;
      supplement_en_o <= 1'b1;
      charge_en_o <= 1'b1;
      end_current_cutoff_on_o <= 1'b1;
      input_limit_code_o <= `CCSR_LIM_100;
      input_limit_ma_o <= `CCSR_MA_0;
      stat_o <= 1'b0;
      stat_oe_o <= 1'b0;
      int_o <= 1'b0;
      int_oe_o <= 1'b0;
    end else begin
      stat_o <= 1'b0;
      int_o <= 1'b0;
      boost_mode_o <= boost & ~ship & ~hiz;
      device_off_o <= ship;
      battery_switch_on_o <= ~ship & (hiz | ~chg_dis);
      external_battery_gate_o <= ship | (~hiz & chg_dis);
      converter_on_o <= ~ship & ~hiz;
      sys_fixed_reg_o <= chg_dis;
      supplement_en_o <= ~ship;
      charge_en_o <= ~chg_dis & ~ship & ~hiz & ~boost;
      end_current_cutoff_on_o <= term_en;
      if (default_mode_o) begin
        input_limit_code_o <= psel_s ? `CCSR_LIM_500 : `CCSR_LIM_100;
        input_limit_ma_o <= lim_ma(psel_s ? `CCSR_LIM_500 : `CCSR_LIM_100);
      end else begin
        input_limit_code_o <= in_limit;
        input_limit_ma_o <= lim_ma(in_limit);
      end
      if (boost | pulse) begin
        // float except for the fault pulse, which outlives boost
        stat_oe_o <= pulse;
        int_oe_o <= pulse;
      end else begin
        stat_oe_o <= (fault_code_i != `CCSR_FAULT_NONE) |
          (stat_en & (charge_phase_i == `CCSR_PHASE_CHARGING));
        int_oe_o <= fault_code_i != `CCSR_FAULT_NONE;
      end
    end
  end

endmodule // ccsr_top

// >>> rtl/ccsr_consts.vh
// constants for the charger control/status register bank
// assumes inclusion by bare name from every rtl file that needs them
`ifndef CCSR_CONSTS_VH
`define CCSR_CONSTS_VH

// serial slave address and register map
`define CCSR_DEV_ADDR 7'h6b
`define CCSR_REG_STATUS 8'h00
`define CCSR_REG_CONTROL 8'h01
`define CCSR_UNMAPPED_DATA 8'hff

// control register defaults; status and control field positions
`define CCSR_CTRL_RESET 8'h0c
`define CCSR_BIT_KICK 7
`define CCSR_BIT_BOOST 6
`define CCSR_BIT_SHIP 3
`define CCSR_BIT_SOFTRST 7
`define CCSR_LIM_HI 6
`define CCSR_LIM_LO 4
`define CCSR_BIT_STATEN 3
`define CCSR_BIT_TERM 2
`define CCSR_BIT_CHGDIS 1
`define CCSR_BIT_HIZ 0

// charging phase and fault codes
`define CCSR_PHASE_CHARGING 2'h1
`define CCSR_FAULT_NONE 3'h0
`define CCSR_FAULT_TIMER 3'h5

// input current limit codes and values in mA
`define CCSR_LIM_100 3'h0
`define CCSR_LIM_500 3'h2
`define CCSR_MA_0 12'h064
`define CCSR_MA_1 12'h096
`define CCSR_MA_2 12'h1f4
`define CCSR_MA_3 12'h384
`define CCSR_MA_4 12'h5dc
`define CCSR_MA_5 12'h79e
`define CCSR_MA_6 12'h9c4
`define CCSR_MA_7 12'h7d0

// boost fault pulse timing
`define CCSR_PULSE_NS 128000
`define CCSR_CLK_MHZ 25

`endif

// >>> rtl/ccsr_sync.v
// two-flop synchroniser for a group of asynchronous pins
// assumes inputs are levels that may change at any time
`timescale 1ns/10ps
module ccsr_sync #(
  parameter W = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // pins
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] meta;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta <= {W{1'b1}};
      sync_o <= {W{1'b1}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // ccsr_sync

// >>> rtl/ccsr_pulse.v
// one-shot pulse stretcher: a trigger gives a pulse of CYCLES clocks
// assumes trigger is synchronous to mclk_i; retrigger restarts the pulse
`timescale 1ns/10ps
module ccsr_pulse #(
  parameter CYCLES = 3200,
  parameter W = 12
) (
  // clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // trigger and pulse
  input wire trig_i,
  output reg pulse_o
);

  reg [W-1:0] cnt;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt <= {W{1'b0}};
      pulse_o <= 1'b0;
    end else if (trig_i) begin
      cnt <= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1};
      pulse_o <= 1'b1;
    end else if (cnt != {W{1'b0}}) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end else begin
      pulse_o <= 1'b0;
    end
  end

endmodule // ccsr_pulse

// >>> testbench/ccsr_top_asserts.sv
// checker for the charger control and status register outputs
// assumes binding to ccsr_top, one clock domain, synchronous reset
`timescale 1ns/10ps
module ccsr_top_asserts (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire logic watchdog_expired_i,
  input wire logic watchdog_kick_o,
  input wire logic watchdog_run_o,
  input wire logic boost_mode_o,
  input wire logic default_mode_o,
  input wire logic device_off_o,
  input wire logic battery_switch_on_o,
  input wire logic external_battery_gate_o,
  input wire logic converter_on_o,
  input wire logic sys_fixed_reg_o,
  input wire logic supplement_en_o,
  input wire logic charge_en_o,
  input wire logic [2:0] input_limit_code_o,
  input wire logic [11:0] input_limit_ma_o,
  input wire logic stat_oe_o,
  input wire logic int_oe_o
);
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_expiry_in_boost;
    watchdog_expired_i && boost_mode_o;
  endsequence
  sequence s_drop_and_pulse;
    ##[1:2] !boost_mode_o ##[0:3] (stat_oe_o && int_oe_o);
  endsequence
  chk_kick_pulse: assert property (watchdog_kick_o |=> !watchdog_kick_o && watchdog_run_o)
    else $error("kick pulse too long or watchdog idle");
  chk_boost_path: assert property (boost_mode_o |-> converter_on_o && !charge_en_o)
    else $error("boost without converter or with charging");
  chk_ship_off: assert property (device_off_o |->
    !converter_on_o && !battery_switch_on_o && external_battery_gate_o)
    else $error("ship latch left something on");
  chk_hiz_state: assert property (!converter_on_o && !device_off_o |->
    battery_switch_on_o && !external_battery_gate_o)
    else $error("high impedance switch or gate wrong");
  chk_charge_gate: assert property (charge_en_o |-> !sys_fixed_reg_o && !boost_mode_o)
    else $error("charging while disabled or boosting");
  chk_fixed_reg: assert property (sys_fixed_reg_o && converter_on_o |->
    !battery_switch_on_o && supplement_en_o)
    else $error("charge disabled but battery still on system");
  chk_default_limit: assert property (default_mode_o && $past(default_mode_o, 3) |->
    input_limit_code_o inside {3'h0, 3'h2})
    else $error("default mode limit not from source pin");
  chk_limit_map: assert property ($stable(input_limit_code_o) && input_limit_code_o[2]
    && input_limit_code_o[0] |-> input_limit_ma_o == (input_limit_code_o[1] ? 12'h7d0 : 12'h79e))
    else $error("limit code to current mapping wrong");
  chk_soft_defaults: assert property ($rose(default_mode_o) |->
    ##[0:2] (!watchdog_run_o && !boost_mode_o))
    else $error("default mode entered with watchdog or boost on");
  chk_wd_boost: assert property (s_expiry_in_boost |-> s_drop_and_pulse)
    else $error("expiry in boost did not drop boost and pulse");
endmodule // ccsr_top_asserts

// >>> testbench/ccsr_host.sv
// two-wire bus master model standing in for the host controller
// assumes sda is pulled up and the slave pulls it low through its enable
`timescale 1ns/10ps
`include "ccsr_consts.vh"
module ccsr_host (
  // bus pins
  output logic scl_o,
  output wire logic sda_o,
  // slave pull-down
  input wire logic sda_oe_i
);
  logic pull_low;
  int nacks;
  // released line rises to the pull-up level
  assign sda_o = (pull_low || sda_oe_i) ? 1'b0 : 1'b1;
  initial begin
    scl_o = 1'b1;
    pull_low = 1'b0;
    nacks = 0;
  end
  // clock stands still between frames; one bit is 320 ns
  task automatic bit_x(input logic b, output logic r);
    #60 pull_low = !b;
    #140 scl_o = 1'b1;
    #100 r = sda_o;
    #20 scl_o = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic want_ack, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(1'b1, a);
    if (want_ack && a !== 1'b0) begin
      nacks++;
    end
  endtask
  task automatic start_c;
    #60 pull_low = 1'b0;
    #140 scl_o = 1'b1;
    #100 pull_low = 1'b1;
    #120 scl_o = 1'b0;
  endtask
  task automatic stop_c;
    #60 pull_low = 1'b1;
    #140 scl_o = 1'b1;
    #100 pull_low = 1'b0;
    #160;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    start_c();
    byte_x({`CCSR_DEV_ADDR, 1'b0}, 1'b1, q);
    byte_x(p, 1'b1, q);
    byte_x(d, 1'b1, q);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    start_c();
    byte_x({`CCSR_DEV_ADDR, 1'b0}, 1'b1, q);
    byte_x(p, 1'b1, q);
    start_c();
    byte_x({`CCSR_DEV_ADDR, 1'b1}, 1'b1, q);
    byte_x(8'hff, 1'b0, d);
    stop_c();
  endtask
endmodule // ccsr_host

// >>> testbench/test_ccsr_top.sv
// self-checking bench for the charger control and status registers
// assumes the design header directory is on the include path
`timescale 1ns/10ps
module test_ccsr_top;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] charge_phase_i = 2'h1;
  logic [2:0] fault_code_i = 3'h0;
  logic watchdog_expired_i = 1'b0;
  logic undervoltage_lockout_i = 1'b0;
  logic source_select_i = 1'b1;
  wire scl_i, sda_i, sda_oe_o, watchdog_kick_o, watchdog_run_o, boost_mode_o, default_mode_o;
  wire device_off_o, battery_switch_on_o, external_battery_gate_o, converter_on_o;
  wire sys_fixed_reg_o, supplement_en_o, charge_en_o, end_current_cutoff_on_o, stat_oe_o, int_oe_o;
  wire sda_o, stat_o, int_o;
  wire [2:0] input_limit_code_o;
  wire [11:0] input_limit_ma_o;
  int fail_count = 0;
  int tests_run = 0;
  int kicks = 0;
  ccsr_top dut (.mclk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .charge_phase_i,
    .fault_code_i, .watchdog_expired_i, .undervoltage_lockout_i, .source_select_i,
    .watchdog_kick_o, .watchdog_run_o, .boost_mode_o, .default_mode_o, .device_off_o,
    .battery_switch_on_o, .external_battery_gate_o, .converter_on_o, .sys_fixed_reg_o,
    .supplement_en_o, .charge_en_o, .end_current_cutoff_on_o, .input_limit_code_o,
    .input_limit_ma_o, .stat_o, .stat_oe_o, .int_o, .int_oe_o);
  ccsr_host host (.scl_o(scl_i), .sda_o(sda_i), .sda_oe_i(sda_oe_o));
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (watchdog_kick_o === 1'b1) kicks++;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(p, d);
    chk({4'h0, d}, {4'h0, exp});
  endtask
  task automatic wrs(input logic [7:0] p, input logic [7:0] d);
    host.wr(p, d);
    cyc(8);
  endtask
  task automatic t_defaults;
    rchk(8'h01, 8'h8c);
    rchk(8'h00, 8'h10);
    rchk(8'h07, 8'hff);
    chk({9'h0, input_limit_code_o}, 12'h002);
    chk({9'h0, default_mode_o, end_current_cutoff_on_o, boost_mode_o}, 12'h006);
    cyc(1);
    source_select_i = 1'b0;
    cyc(8);
    chk({9'h0, input_limit_code_o}, 12'h000);
  endtask
  task automatic t_kick;
    kicks = 0;
    wrs(8'h00, 8'h80);
    chk(kicks[11:0], 12'h001);
    chk({11'h0, watchdog_run_o}, 12'h001);
    rchk(8'h00, 8'h10);
  endtask
  task automatic t_boost_expiry;
    wrs(8'h00, 8'h40);
    rchk(8'h00, 8'h50);
    chk({10'h0, boost_mode_o, converter_on_o}, 12'h003);
    cyc(1);
    watchdog_expired_i = 1'b1;
    cyc(1);
    watchdog_expired_i = 1'b0;
    cyc(10);
    chk({10'h0, boost_mode_o, int_oe_o}, 12'h001);
    cyc(3140);
    chk({11'h0, int_oe_o}, 12'h001);
    cyc(100);
    chk({10'h0, stat_oe_o, int_oe_o}, 12'h002);
    rchk(8'h00, 8'h10);
  endtask
  task automatic t_fault_codes;
    charge_phase_i = 2'h3;
    for (int f = 0; f < 8; f++) begin
      cyc(1);
      fault_code_i = f[2:0];
      rchk(8'h00, {5'h06, f[2:0]});
      chk({11'h0, int_oe_o}, {11'h0, f != 0});
    end
    cyc(1);
    fault_code_i = 3'h0;
    charge_phase_i = 2'h1;
  endtask
  task automatic t_limits;
    logic [11:0] ma [8] = '{12'h064, 12'h096, 12'h1f4, 12'h384, 12'h5dc, 12'h79e, 12'h9c4, 12'h7d0};
    for (int c = 0; c < 8; c++) begin
      wrs(8'h01, {1'b0, c[2:0], 4'hc});
      chk({9'h0, input_limit_code_o}, {9'h0, c[2:0]});
      chk(input_limit_ma_o, ma[c]);
    end
  endtask
  task automatic t_ctrl_bits;
    wrs(8'h01, 8'h02);
    chk({5'h0, charge_en_o, sys_fixed_reg_o, battery_switch_on_o, external_battery_gate_o,
      supplement_en_o, end_current_cutoff_on_o, stat_oe_o}, 12'h02c);
    chk({11'h0, stat_oe_o}, 12'h000);
    wrs(8'h01, 8'h09);
    chk({7'h0, converter_on_o, battery_switch_on_o, external_battery_gate_o, charge_en_o,
      stat_oe_o}, 12'h009);
    rchk(8'h01, 8'h89);
  endtask
  task automatic t_ship;
    wrs(8'h00, 8'h08);
    chk({8'h0, device_off_o, converter_on_o, battery_switch_on_o, external_battery_gate_o},
      12'h009);
    rchk(8'h00, 8'h18);
    wrs(8'h00, 8'h00);
    chk({11'h0, device_off_o}, 12'h000);
    wrs(8'h00, 8'h08);
    undervoltage_lockout_i = 1'b1;
    cyc(8);
    chk({11'h0, device_off_o}, 12'h001);
    undervoltage_lockout_i = 1'b0;
    cyc(8);
    chk({11'h0, device_off_o}, 12'h000);
  endtask
  task automatic t_soft_reset;
    wrs(8'h01, 8'h75);
    wrs(8'h00, 8'hc8);
    wrs(8'h01, 8'h80);
    rchk(8'h01, 8'h8c);
    rchk(8'h00, 8'h10);
    chk({8'h0, default_mode_o, watchdog_run_o, boost_mode_o, device_off_o}, 12'h008);
    chk({9'h0, input_limit_code_o}, 12'h000);
    wrs(8'h01, 8'h34);
    rchk(8'h01, 8'hb4);
  endtask
  initial begin
    cyc(10);
    sys_rst_i = 1'b0;
    cyc(10);
    t_defaults();
    t_kick();
    t_boost_expiry();
    t_fault_codes();
    t_limits();
    t_ctrl_bits();
    t_ship();
    t_soft_reset();
    chk(host.nacks[11:0], 12'h000);
    chk({9'h0, sda_o, stat_o, int_o}, 12'h000);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    fail_count++;
    $display("mismatch at %0t: run timed out", $time);
    summarize();
  end
endmodule // test_ccsr_top

bind ccsr_top ccsr_top_asserts chk (.mclk_i, .sys_rst_i, .watchdog_expired_i, .watchdog_kick_o,
  .watchdog_run_o, .boost_mode_o, .default_mode_o, .device_off_o, .battery_switch_on_o,
  .external_battery_gate_o, .converter_on_o, .sys_fixed_reg_o, .supplement_en_o, .charge_en_o,
  .input_limit_code_o, .input_limit_ma_o, .stat_oe_o, .int_oe_o);
